// ### bench/halfband_interp_zero_stuff_bench.sv
/*
 * Self-checking bench: four modes through the filter, then input order with a paused source.
 * Assumes the core clock is four times the input rate.
 */
`timescale 1ns/1ns
`default_nettype none
module halfband_interp_zero_stuff_bench;
    localparam int NW = 32;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        hp = 1'b0;
    logic        st = 1'b0;
    logic        run = 1'b0;
    logic [13:0] word = 14'h3fff;
    logic        take;
    logic        in_clk;
    logic [13:0] in_data;
    logic [13:0] dac;
    logic        strobe;
    logic        ovr;
    logic        und;
    logic [15:0] seed = 16'h0024;
    int          error_cnt = 0;
    int          comparisons = 0;
    int          xs[$];
    logic [13:0] d[$];

    always #20 clk = ~clk;

    hbz_interp_top #(.FIFO_DEPTH(16)) DUT (.CORE_CLK_I(clk), .RST_N_I(rst_n), .IN_CLK_I(in_clk),
        .IN_DATA_I(in_data), .FILTER_RESPONSE_SELECT_I(hp), .ZERO_STUFF_SELECT_I(st),
        .DAC_DATA_O(dac), .DAC_STROBE_O(strobe), .OVERRUN_O(ovr), .UNDERRUN_O(und));
    hbz_src_model SRC (.clk_i(clk), .rst_n_i(rst_n), .run_i(run), .word_i(word), .take_o(take),
        .in_clk_o(in_clk), .in_data_o(in_data));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    // Saturate a signed result and return it as offset binary
    function automatic logic [13:0] sat_out(input longint v);
        if (v > 8191) v = 8191;
        if (v < -8192) v = -8192;
        return 14'(v) ^ 14'h2000;
    endfunction : sat_out

    task automatic cmp_word(input logic [13:0] got, input logic [13:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_word

    task automatic cmp_flag(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_flag

    task automatic results();
        if (error_cnt == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results

    // Corner words first: full scale, zero (saturates when negated), just above midscale
    always @(posedge clk) begin
        if (take) begin
            xs.push_back(int'($signed(word ^ 14'h2000)));
            seed <= lfsr(seed);
            word <= (xs.size() == 1) ? 14'h0000 : (xs.size() == 2) ? 14'h2001 : seed[13:0];
            if (xs.size() >= NW) run <= 1'b0;
        end
    end

    task automatic run_mode(input logic m_hp, input logic m_st);
        int          h[22];
        logic [13:0] e[$];
        int          best;
        int          bm;
        int          m;
        int          k;
        longint      acc;
        logic        prv;
        rst_n <= 1'b0;
        run   <= 1'b0;
        hp    <= m_hp;
        st    <= m_st;
        repeat (12) @(posedge clk);
        xs.delete();
        d.delete();
        word  <= 14'h3fff;
        rst_n <= 1'b1;
        @(posedge clk);
        run  <= 1'b1;
        prv  = 1'b0;
        k    = 0;
        // First frame runs on the reset mode, so checks start at the second frame's first word
        for (int n = 0; n < 420; n++) begin
            @(posedge clk);
            #1;
            if (n > 5) cmp_flag(strobe, m_st ? 1'b1 : ~prv);
            prv = strobe;
            if (n >= 5 && strobe === 1'b1) begin
                if (!m_st || k % 2 == 0) d.push_back(dac);
                else cmp_word(dac, hbz_pkg::MIDSCALE);
                k++;
            end
        end
        // Source rate equals frame rate, so nothing drops; the stall starves the filter
        cmp_flag(ovr, 1'b0);
        cmp_flag(und, 1'b1);
        foreach (h[i]) h[i] = 0;
        for (int f = 0; f < NW + 22; f++) begin
            for (int i = 21; i > 0; i--) h[i] = h[i-1];
            h[0] = (f < xs.size()) ? xs[f] : 0;
            acc  = 0;
            for (int j = 0; j < 11; j++) acc += longint'(hbz_pkg::SIDE_COEF[j]) * (h[j] + h[21-j]);
            e.push_back(sat_out((acc + 8192) >>> 14));
            e.push_back(sat_out(m_hp ? -h[10] : h[10]));
        end
        // Latency is not fixed by the rules, so align on whole frames first
        bm   = 1 << 30;
        best = 0;
        for (int o = 0; o <= 40; o += 2) begin
            m = 0;
            for (int j = 0; j < e.size(); j++)
                if (o + j >= d.size() || d[o+j] !== e[j]) m++;
            if (m < bm) begin
                bm   = m;
                best = o;
            end
        end
        for (int j = 0; j < e.size(); j++)
            cmp_word((best + j < d.size()) ? d[best+j] : 14'hxxxx, e[j]);
    endtask : run_mode

    // A paused source starves the filter but must never reorder, drop or repeat a word
    task automatic order_test();
        logic [13:0] q[$];
        int          j;
        rst_n <= 1'b0;
        run   <= 1'b0;
        hp    <= 1'b0;
        st    <= 1'b0;
        repeat (12) @(posedge clk);
        xs.delete();
        d.delete();
        word  <= 14'h3fff;
        rst_n <= 1'b1;
        @(posedge clk);
        run <= 1'b1;
        for (int n = 0; n < 400; n++) begin
            @(posedge clk);
            if (n == 40) run <= 1'b0;
            if (n == 80) run <= 1'b1;
            #1;
            if (n >= 5 && strobe === 1'b1) d.push_back(dac);
        end
        // Low-pass centre phase replays each popped word; starved frames show midscale
        for (int i = 1; i < d.size(); i += 2)
            if (d[i] !== hbz_pkg::MIDSCALE) q.push_back(d[i]);
        j = 0;
        foreach (xs[i]) begin
            if (xs[i] != 0) begin
                cmp_word((j < q.size()) ? q[j] : 14'hxxxx, 14'(xs[i]) ^ 14'h2000);
                j++;
            end
        end
        cmp_word(14'(q.size()), 14'(j));
        cmp_word(d[d.size()-1], hbz_pkg::MIDSCALE);
        cmp_flag(ovr, 1'b0);
        cmp_flag(und, 1'b1);
    endtask : order_test

    initial begin
        repeat (100000) @(posedge clk);
        error_cnt++;
        results();
    end

    initial begin
        for (int m = 0; m < 4; m++) run_mode(m[0], m[1]);
        order_test();
        results();
    end
endmodule : halfband_interp_zero_stuff_bench
`default_nettype wire

// ### bench/hbz_src_model.sv
/*
 * Behavioural data source on the input bus of the interpolator.
 * Assumes one core clock; the input clock it makes is a quarter of it.
 */
`timescale 1ns/1ns
`default_nettype none
module hbz_src_model (
    input  wire logic                       clk_i,
    input  wire logic                       rst_n_i,
    input  wire logic                       run_i,
    input  wire logic [hbz_pkg::DATA_W-1:0] word_i,
    output logic                            take_o,
    output logic                            in_clk_o,
    output logic      [hbz_pkg::DATA_W-1:0] in_data_o
);
    logic [1:0] ph_r;

    assign take_o = run_i && (ph_r == 2'h0);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ph_r      <= 2'h0;
            in_clk_o  <= 1'b0;
            in_data_o <= 14'h1555;
        end else begin
            // Finish a started period so the clock stands low when idle
            if (run_i || ph_r != 2'h0) begin
                ph_r <= ph_r + 2'h1;
            end
            in_clk_o <= (ph_r == 2'h1) || (ph_r == 2'h2);
            if (take_o) begin
                in_data_o <= word_i;
            end else if (ph_r == 2'h0) begin
                // Idle bus toggles each cycle between the last word and its inverse
                in_data_o <= ~in_data_o;
            end
        end
    end
endmodule : hbz_src_model
`default_nettype wire

// ### design/hbz_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes DEPTH is a power of two; both sides on one clock.
 */
`timescale 1ns/1ns
`default_nettype none
module hbz_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             wr_valid_i,
    input  wire logic [WIDTH-1:0] wr_data_i,
    output logic                  wr_ready_o,
    output logic                  rd_valid_o,
    output logic      [WIDTH-1:0] rd_data_o,
    input  wire logic             rd_ready_i
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("hbz_fifo: DEPTH must be a power of two");
    end

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic             wr_fire;
    logic             rd_fire;

    assign wr_ready_o = (count_r != (AW+1)'(DEPTH));
    assign rd_valid_o = (count_r != '0);
    assign rd_data_o  = mem_r[rd_ptr_r];
    assign wr_fire    = wr_valid_i & wr_ready_o;
    assign rd_fire    = rd_ready_i & rd_valid_o;

    always_ff @(posedge clk_i) begin
        if (wr_fire) begin
            mem_r[wr_ptr_r] <= wr_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (wr_fire) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (rd_fire) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (wr_fire && !rd_fire) begin
                count_r <= count_r + 1'b1;
            end else if (rd_fire && !wr_fire) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule : hbz_fifo
`default_nettype wire

// ### design/hbz_interp_top.sv
/*
 * 2x half-band interpolator with optional midscale stuffing ahead of a
 * 14-bit DAC. Assumes the core clock runs at four times the input rate
 * and that the input clock and mode pins are asynchronous to it.
 */
// Overview of operation
// RULE1 - Interpolator is a 43-tap symmetric half-band FIR.
// RULE2 - Response select low gives low-pass, high gives high-pass.
// RULE3 - Two filter outputs for every input sample taken.
// RULE4 - Zero taps stay zero; high-pass only negates the centre tap.
// RULE5 - High-pass equals low-pass impulse response mixed at half output rate.
// RULE6 - Stuff select high enables stuffing, low bypasses it.
// RULE7 - Stuffing follows every filter sample with one midscale word.
// RULE8 - Stuffing mux alternates filter and midscale at four times input rate.
// RULE9 - High-pass with stuffing equals low-pass mixed at quarter DAC rate.
// RULE10 - Data path is 14 bits wide from input to DAC.
// RULE11 - Input words captured on rising edge of the input clock.
// RULE12 - Coefficients are constants: symmetric, zero alternate taps, big centre.
`timescale 1ns/1ns
`default_nettype none
module hbz_interp_top #(
    parameter int FIFO_DEPTH = hbz_pkg::FIFO_DEPTH
) (
    input  wire logic                     CORE_CLK_I,
    input  wire logic                     RST_N_I,
    input  wire logic                     IN_CLK_I,
    input  wire logic [hbz_pkg::DATA_W-1:0] IN_DATA_I,
    input  wire logic                     FILTER_RESPONSE_SELECT_I,
    input  wire logic                     ZERO_STUFF_SELECT_I,
    output logic      [hbz_pkg::DATA_W-1:0] DAC_DATA_O,
    output logic                          DAC_STROBE_O,
    output logic                          OVERRUN_O,
    output logic                          UNDERRUN_O
);
    localparam int DW = hbz_pkg::DATA_W;
    localparam int HL = hbz_pkg::HIST_LEN;
    localparam int NU = hbz_pkg::UNIQ_COEF;
    localparam int AW = hbz_pkg::ACC_W;

    if (2 * HL - 1 != hbz_pkg::NUM_TAPS) begin : g_bad_taps
        $error("hbz_interp_top: tap count mismatch");
    end
    if (FIFO_DEPTH < 2) begin : g_bad_depth
        $error("hbz_interp_top: FIFO_DEPTH too small");
    end

    // Round, shift out the fraction, clip to the data width
    function automatic logic signed [DW-1:0] sat_round(
        input logic signed [AW-1:0] acc
    );
        logic signed [AW-1:0] sh;
        sh = (acc + AW'(1 << (hbz_pkg::COEF_FRAC - 1)))
             >>> hbz_pkg::COEF_FRAC;
        if (sh > AW'(2 ** (DW - 1) - 1)) begin
            sat_round = {1'b0, {(DW-1){1'b1}}};
        end else if (sh < -AW'(2 ** (DW - 1))) begin
            sat_round = {1'b1, {(DW-1){1'b0}}};
        end else begin
            sat_round = sh[DW-1:0];
        end
    endfunction : sat_round

    // Offset binary and two's complement differ in the top bit only
    function automatic logic [DW-1:0] flip_msb(input logic [DW-1:0] w);
        flip_msb = {~w[DW-1], w[DW-2:0]};
    endfunction : flip_msb

    // Pin synchronisers
    logic [1:0]    in_clk_sync_r;
    logic          in_clk_prev_r;
    logic [DW-1:0] in_data_s1_r;
    logic [DW-1:0] in_data_s2_r;
    logic [1:0]    hp_sync_r;
    logic [1:0]    zs_sync_r;

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            in_clk_sync_r <= '0;
            in_clk_prev_r <= 1'b0;
            in_data_s1_r  <= '0;
            in_data_s2_r  <= '0;
            hp_sync_r     <= '0;
            zs_sync_r     <= '0;
        end else begin
            in_clk_sync_r <= {in_clk_sync_r[0], IN_CLK_I};
            in_clk_prev_r <= in_clk_sync_r[1];
            in_data_s1_r  <= IN_DATA_I;
            in_data_s2_r  <= in_data_s1_r;
            hp_sync_r     <= {hp_sync_r[0], FILTER_RESPONSE_SELECT_I};
            zs_sync_r     <= {zs_sync_r[0], ZERO_STUFF_SELECT_I};
        end
    end

    // Input capture into the FIFO
    logic          fifo_wr_valid;
    logic          fifo_wr_ready;
    logic          fifo_rd_valid;
    logic          fifo_rd_ready;
    logic [DW-1:0] fifo_rd_data;

    assign fifo_wr_valid = in_clk_sync_r[1] & ~in_clk_prev_r; // RULE11

    hbz_fifo #(
        .WIDTH (DW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i      (CORE_CLK_I),
        .rst_n_i    (RST_N_I),
        .wr_valid_i (fifo_wr_valid),
        .wr_data_i  (in_data_s2_r),
        .wr_ready_o (fifo_wr_ready),
        .rd_valid_o (fifo_rd_valid),
        .rd_data_o  (fifo_rd_data),
        .rd_ready_i (fifo_rd_ready)
    );

    // Frame sequencer, one input sample per four core cycles
    hbz_pkg::hbz_phase_t phase_r;
    hbz_pkg::hbz_phase_t phase_nxt;
    hbz_pkg::hbz_mode_t  mode_r;

    always_comb begin
        case (phase_r)
            hbz_pkg::PH_LOAD:  phase_nxt = hbz_pkg::PH_CALC;
            hbz_pkg::PH_CALC:  phase_nxt = hbz_pkg::PH_FIRST;
            hbz_pkg::PH_FIRST: phase_nxt = hbz_pkg::PH_GAP;
            hbz_pkg::PH_GAP:   phase_nxt = hbz_pkg::PH_LOAD;
            default:           phase_nxt = hbz_pkg::PH_LOAD;
        endcase
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            phase_r <= hbz_pkg::PH_LOAD;
        end else begin
            phase_r <= phase_nxt;
        end
    end

    // Pins are static; sampling once per frame keeps a frame coherent
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            mode_r <= '0;
        end else if (phase_r == hbz_pkg::PH_LOAD) begin
            mode_r.high_pass  <= hp_sync_r[1]; // RULE2
            mode_r.zero_stuff <= zs_sync_r[1]; // RULE6
        end
    end

    // One pop per frame: one input yields two outputs
    assign fifo_rd_ready = (phase_r == hbz_pkg::PH_LOAD); // RULE3

    // Sample history, newest at index 0
    logic signed [DW-1:0] hist_r [HL];

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            for (int i = 0; i < HL; i++) begin
                hist_r[i] <= '0;
            end
        end else if (phase_r == hbz_pkg::PH_LOAD) begin
            // Starved frames feed midscale rather than stale data
            hist_r[0] <= fifo_rd_valid ? flip_msb(fifo_rd_data) : '0; // RULE10
            for (int i = 1; i < HL; i++) begin
                hist_r[i] <= hist_r[i-1];
            end
        end
    end

    // Polyphase arithmetic
    logic signed [DW:0]   pair_sum [NU];
    logic signed [AW-1:0] side_acc;
    logic signed [AW-1:0] ctr_acc;
    logic signed [AW-1:0] coef_sum;

    always_comb begin
        side_acc = '0;
        coef_sum = '0;
        for (int i = 0; i < NU; i++) begin
            // Folded symmetric pair shares one multiplier
            pair_sum[i] = (DW+1)'(hist_r[i]) + (DW+1)'(hist_r[HL-1-i]); // RULE1
            side_acc = side_acc + AW'(pair_sum[i]) * AW'(hbz_pkg::SIDE_COEF[i]); // RULE12
            coef_sum = coef_sum + AW'(hbz_pkg::SIDE_COEF[i]);
        end
    end

    // The other phase holds only the centre tap; every other tap is zero
    always_comb begin
        ctr_acc = AW'(hist_r[hbz_pkg::CENTER_IDX]) * AW'(hbz_pkg::CENTER_COEF);
        if (mode_r.high_pass) begin
            ctr_acc = -ctr_acc; // RULE4 RULE5 RULE9
        end
    end

    hbz_pkg::hbz_pair_t pair_r;

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            pair_r.first  <= hbz_pkg::OUT_RESET;
            pair_r.second <= hbz_pkg::OUT_RESET;
        end else if (phase_r == hbz_pkg::PH_CALC) begin
            pair_r.first  <= flip_msb(sat_round(side_acc)); // RULE3
            pair_r.second <= flip_msb(sat_round(ctr_acc)); // RULE3
        end
    end

    // Output stage
    hbz_stuff_mux u_stuff (
        .clk_i    (CORE_CLK_I),
        .rst_n_i  (RST_N_I),
        .phase_i  (phase_r),
        .pair_i   (pair_r),
        .stuff_i  (mode_r.zero_stuff),
        .dac_o    (DAC_DATA_O),
        .strobe_o (DAC_STROBE_O)
    );

    // Sticky error flags, cleared only by reset
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            OVERRUN_O <= 1'b0;
        end else if (fifo_wr_valid && !fifo_wr_ready) begin
            OVERRUN_O <= 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            UNDERRUN_O <= 1'b0;
        end else if (fifo_rd_ready && !fifo_rd_valid) begin
            UNDERRUN_O <= 1'b1;
        end
    end

    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    logic signed [DW-1:0] odd_signed;
    assign odd_signed = flip_msb(pair_r.second);

    a_coef_gain: assert property (coef_sum == AW'(hbz_pkg::SIDE_SUM)) // RULE12
        else $error("side coefficients lost unity gain");

    a_tap_fold: assert property ( // RULE1
        phase_r == hbz_pkg::PH_CALC && side_acc == '0 |=> pair_r.first == hbz_pkg::MIDSCALE)
        else $error("zero folded sum gave nonzero output");

    a_mode_latch: assert property ( // RULE2
        phase_r == hbz_pkg::PH_LOAD |=> mode_r.high_pass == $past(hp_sync_r[1]))
        else $error("response select not taken at frame start");

    a_pop_per_frame: assert property ( // RULE3
        fifo_rd_ready |=> !fifo_rd_ready [*3] ##1 fifo_rd_ready)
        else $error("input taken more than once per frame");

    a_lp_centre: assert property ( // RULE4
        phase_r == hbz_pkg::PH_CALC && !mode_r.high_pass
        |=> odd_signed == $past(hist_r[hbz_pkg::CENTER_IDX]))
        else $error("low-pass centre phase wrong");

    a_hp_centre: assert property ( // RULE5
        phase_r == hbz_pkg::PH_CALC && mode_r.high_pass
        && hist_r[hbz_pkg::CENTER_IDX] != {1'b1, {(DW-1){1'b0}}}
        |=> odd_signed == -$past(hist_r[hbz_pkg::CENTER_IDX]))
        else $error("high-pass centre phase not negated");

    a_stuff_midscale: assert property ( // RULE7
        mode_r.zero_stuff && phase_r == hbz_pkg::PH_GAP
        |=> DAC_DATA_O == hbz_pkg::MIDSCALE)
        else $error("stuffed slot not midscale");

    a_stuff_rate: assert property ( // RULE8
        mode_r.zero_stuff |=> DAC_STROBE_O)
        else $error("stuffing mux not updating every cycle");

    a_plain_rate: assert property ( // RULE6
        DAC_STROBE_O && !mode_r.zero_stuff && $past(!mode_r.zero_stuff)
        |=> !DAC_STROBE_O)
        else $error("unstuffed output faster than 2x");

    a_quarter_mix: assert property ( // RULE9
        mode_r.high_pass && mode_r.zero_stuff && zs_sync_r[1] && phase_r == hbz_pkg::PH_LOAD
        |=> DAC_DATA_O == $past(pair_r.second) ##1 DAC_DATA_O == hbz_pkg::MIDSCALE)
        else $error("quarter-rate mix sequence broken");

    a_capture_edge: assert property ( // RULE11
        $rose(in_clk_sync_r[1]) |-> fifo_wr_valid ##1 !fifo_wr_valid)
        else $error("input edge not captured once");

    a_underrun_flag: assert property ( // RULE3
        fifo_rd_ready && !fifo_rd_valid |=> UNDERRUN_O)
        else $error("underrun not flagged");

    c_hp_stuff: cover property (mode_r.high_pass && mode_r.zero_stuff && DAC_STROBE_O);
    c_lp_plain: cover property (!mode_r.high_pass && !mode_r.zero_stuff && DAC_STROBE_O);
    c_overrun:  cover property (fifo_wr_valid && !fifo_wr_ready);
    c_underrun: cover property (fifo_rd_ready && !fifo_rd_valid);
endmodule : hbz_interp_top
`default_nettype wire

// ### design/hbz_pkg.sv
/*
 * Shared constants and types of the half-band interpolator with zero stuffing.
 * Assumes one core clock at four times the input sample rate.
 */
package hbz_pkg;
    localparam int DATA_W     = 14;
    localparam int COEF_W     = 16;
    localparam int COEF_FRAC  = 14;
    localparam int NUM_TAPS   = 43;
    localparam int HIST_LEN   = 22;
    localparam int UNIQ_COEF  = 11;
    localparam int CENTER_IDX = 10;
    localparam int FIFO_DEPTH = 16;
    localparam int ACC_W      = 36;
    localparam int CORE_CLK_MHZ = 25;
    localparam int SIDE_SUM   = 8192;

    // Offset binary midscale word
    localparam logic [DATA_W-1:0] MIDSCALE = 14'h2000;
    localparam logic [DATA_W-1:0] OUT_RESET = MIDSCALE;

    // Centre tap is unity gain in the 2x path
    localparam logic signed [COEF_W-1:0] CENTER_COEF = 16'sh4000;

    // Index 0 sits farthest from the centre
    localparam logic signed [COEF_W-1:0] SIDE_COEF [UNIQ_COEF] = '{
        16'sh0003, 16'shfff6, 16'sh001d, 16'shffba,
        16'sh0096, 16'shfed9, 16'sh0220, 16'shfc3c,
        16'sh06b6, 16'shf33c, 16'sh2873
    };

    typedef enum logic [1:0] {
        PH_LOAD,
        PH_CALC,
        PH_FIRST,
        PH_GAP
    } hbz_phase_t;

    typedef struct packed {
        logic high_pass;
        logic zero_stuff;
    } hbz_mode_t;

    typedef struct packed {
        logic [DATA_W-1:0] first;
        logic [DATA_W-1:0] second;
    } hbz_pair_t;
endpackage : hbz_pkg

// ### design/hbz_stuff_mux.sv
/*
 * Output multiplexer: filter pair or midscale, one slot per core cycle.
 * Assumes the pair is stable from the calc phase up to the next one.
 */
`timescale 1ns/1ns
`default_nettype none
module hbz_stuff_mux (
    input  wire logic                     clk_i,
    input  wire logic                     rst_n_i,
    input  wire hbz_pkg::hbz_phase_t      phase_i,
    input  wire hbz_pkg::hbz_pair_t       pair_i,
    input  wire logic                     stuff_i,
    output logic [hbz_pkg::DATA_W-1:0]    dac_o,
    output logic                          strobe_o
);
    // Slots alternate at the core rate, four per input sample
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            dac_o    <= hbz_pkg::OUT_RESET;
            strobe_o <= 1'b0;
        end else begin
            case (phase_i)
                hbz_pkg::PH_FIRST: begin
                    dac_o    <= pair_i.first;
                    strobe_o <= 1'b1;
                end
                hbz_pkg::PH_LOAD: begin
                    dac_o    <= pair_i.second;
                    strobe_o <= 1'b1;
                end
                hbz_pkg::PH_GAP, hbz_pkg::PH_CALC: begin
                    // Unstuffed: hold so the DAC sees a 2x word rate
                    dac_o    <= stuff_i ? hbz_pkg::MIDSCALE : dac_o; // RULE7 RULE8
                    strobe_o <= stuff_i; // RULE6
                end
                default: begin
                    dac_o    <= hbz_pkg::MIDSCALE;
                    strobe_o <= 1'b0;
                end
            endcase
        end
    end
endmodule : hbz_stuff_mux
`default_nettype wire
